// >>> design/tmc_pkg.sv
// constants, field layouts and mode encodings for the 8-bit timer slice
// assumes: a 32-bit apb slave with 8-bit byte addresses
package tmc_pkg;

  localparam int unsigned TMC_ADDR_W = 8;
  localparam int unsigned TMC_DATA_W = 32;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TMC_OFS_CTRLA  = 8'h00;
  localparam logic [7:0] TMC_OFS_CTRLB  = 8'h04;
  localparam logic [7:0] TMC_OFS_COUNT  = 8'h08;
  localparam logic [7:0] TMC_OFS_CMPA   = 8'h0c;
  localparam logic [7:0] TMC_OFS_FLAGS  = 8'h10;
  localparam logic [7:0] TMC_OFS_IRQEN  = 8'h14;
  localparam logic [7:0] TMC_OFS_PORT   = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned TMC_MODE_LSB   = 0;
  localparam int unsigned TMC_ACT_LSB    = 4;
  localparam int unsigned TMC_FORCE_BIT  = 7;
  localparam int unsigned TMC_CS_LSB     = 0;
  localparam int unsigned TMC_OVF_BIT    = 0;
  localparam int unsigned TMC_CMP_BIT    = 1;
  localparam int unsigned TMC_PDATA_BIT  = 0;
  localparam int unsigned TMC_PDIR_BIT   = 1;

  // ---------------------------------------------------------------
  // counter extremes and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] TMC_BOTTOM    = 8'h00;
  localparam logic [7:0] TMC_MAX       = 8'hff;
  localparam logic [7:0] TMC_STEP      = 8'h01;
  localparam logic [7:0] TMC_RST_COUNT = 8'h00;
  localparam logic [7:0] TMC_RST_CMP   = 8'h00;

  // ---------------------------------------------------------------
  // clock source select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] TMC_CS_STOP   = 3'h0;
  localparam logic [2:0] TMC_CS_CLK    = 3'h1;
  localparam logic [2:0] TMC_CS_EXTFALL = 3'h6;
  localparam logic [2:0] TMC_CS_EXTRISE = 3'h7;

  typedef enum logic [1:0] {
    TMC_NORMAL = 2'b00,
    TMC_PCPWM  = 2'b01,
    TMC_CTC    = 2'b10,
    TMC_FAST   = 2'b11
  } tmc_mode_e;

  typedef enum logic [1:0] {
    TMC_ACT_NONE   = 2'b00,
    TMC_ACT_TOGGLE = 2'b01,
    TMC_ACT_CLEAR  = 2'b10,
    TMC_ACT_SET    = 2'b11
  } tmc_act_e;

endpackage

// >>> design/tmc_timer8.sv
// 8-bit timer/counter with one compare channel and pin override, apb registers
// assumes: apb master on clk; prescaleTick is a one-cycle pulse on clk;
//          extTickPin is asynchronous and slower than clk/2
// Notes on behaviour
// - each tick clears, increments or decrements the count as the mode dictates
// - clock source select zero gives no tick, counter stops
// - software reads and writes the count at any time
// - a software count write beats any clear or count in that cycle
// - two mode bits in control register a choose the count sequence
// - overflow flag sets per mode and can raise an interrupt
// - comparator flags a match only on a tick where count equals compare value a
// - a match sets the compare flag at the clock edge that ends the matching tick
// - with enable set the flag requests an interrupt, cleared on acknowledge
// - writing one to the compare flag bit clears it
// - output formed from match, mode and action bits, extremes via max in fast pwm only
// - compare value buffered in pwm modes, direct in normal and clear modes
// - buffered compare value loads only on a tick at max
// - software reaches buffer when buffered, working register otherwise
// - force strobe in non-pwm modes acts like a match, no flag, no clear
// - any count write blocks a match on the next tick, even when stopped
// - output state survives a mode change
// - action bits act at once, governing the first match after the write
// - nonzero action routes output state to pin, direction bit still gates it
// - action zero leaves the output state alone on a match
// - mode codes are normal 0, phase correct 1, clear on match 2, fast 3
// - bottom is 0x00, max is 0xff, top is max or compare value
`timescale 1ns/1ps

module tmc_timer8 (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        prescaleTick,
  input  wire logic        extTickPin,
  input  wire logic        cmpIrqAck,
  input  wire logic        ovfIrqAck,
  output logic             cmpIrq,
  output logic             ovfIrq,
  output logic             compareOutPin,
  output logic             compareOutPinOe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        count;
    logic              countUp;
    logic [7:0]        cmpWork;
    logic [7:0]        cmpBuf;
    tmc_pkg::tmc_mode_e mode;
    tmc_pkg::tmc_act_e  action;
    logic [2:0]        clkSel;
    logic              ovfFlag;
    logic              cmpFlag;
    logic              ovfIe;
    logic              cmpIe;
    logic              portData;
    logic              portDir;
    logic              ocState;
    logic              blockMatch;
    logic              syncA;
    logic              syncB;
    logic              extPrev;
    logic [31:0]       rdata;
    logic              outPin;
    logic              outOe;
  } tmc_state_s;

  tmc_state_s q;
  tmc_state_s d;

  logic       wrEn;
  logic       rdSetup;
  logic       addrOk;
  logic       tick;
  logic       isPwm;
  logic       atMax;
  logic       atBot;
  logic       matchSig;
  logic       cmpEvent;
  logic       forceEv;
  logic       ovfSet;
  logic       cmpSet;
  logic [7:0] cntNext;
  logic       upNext;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  always_comb begin
    case (paddr)
      tmc_pkg::TMC_OFS_CTRLA,
      tmc_pkg::TMC_OFS_CTRLB,
      tmc_pkg::TMC_OFS_COUNT,
      tmc_pkg::TMC_OFS_CMPA,
      tmc_pkg::TMC_OFS_FLAGS,
      tmc_pkg::TMC_OFS_IRQEN,
      tmc_pkg::TMC_OFS_PORT:  addrOk = 1'b1;
      default:                addrOk = 1'b0;
    endcase
  end

  // zero wait states: every mapped access ends in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addrOk;
  assign wrEn    = psel & penable & pwrite & addrOk;
  assign rdSetup = psel & ~penable & ~pwrite;

  // ---------------------------------------------------------------
  // tick selection
  // ---------------------------------------------------------------
  always_comb begin
    case (q.clkSel)
      tmc_pkg::TMC_CS_STOP:    tick = 1'b0;
      tmc_pkg::TMC_CS_CLK:     tick = 1'b1;
      tmc_pkg::TMC_CS_EXTFALL: tick = q.extPrev & ~q.syncB;
      tmc_pkg::TMC_CS_EXTRISE: tick = ~q.extPrev & q.syncB;
      // select codes two to five share the prescaler pulse
      default:                 tick = prescaleTick;
    endcase
  end

  // ---------------------------------------------------------------
  // comparator and mode decode
  // ---------------------------------------------------------------
  assign isPwm    = (q.mode == tmc_pkg::TMC_PCPWM) | (q.mode == tmc_pkg::TMC_FAST);
  assign atMax    = (q.count == tmc_pkg::TMC_MAX);
  assign atBot    = (q.count == tmc_pkg::TMC_BOTTOM);
  assign matchSig = (q.count == q.cmpWork);
  // a tick right after a count write drops its match once
  assign cmpEvent = tick & matchSig & ~q.blockMatch;
  // force is gated by the mode held before this write
  assign forceEv  = wrEn & (paddr == tmc_pkg::TMC_OFS_CTRLA)
                  & pwdata[tmc_pkg::TMC_FORCE_BIT] & ~isPwm;

  // ---------------------------------------------------------------
  // counting sequence per mode
  // ---------------------------------------------------------------
  always_comb begin
    cntNext = q.count;
    upNext  = q.countUp;
    ovfSet  = 1'b0;
    case (q.mode)
      tmc_pkg::TMC_NORMAL: begin
        cntNext = q.count + tmc_pkg::TMC_STEP;
        upNext  = 1'b1;
        ovfSet  = atMax;
      end
      tmc_pkg::TMC_CTC: begin
        upNext  = 1'b1;
        ovfSet  = atMax;
        if (matchSig) begin
          cntNext = tmc_pkg::TMC_BOTTOM;
        end else begin
          cntNext = q.count + tmc_pkg::TMC_STEP;
        end
      end
      tmc_pkg::TMC_FAST: begin
        cntNext = q.count + tmc_pkg::TMC_STEP;
        upNext  = 1'b1;
        ovfSet  = atMax;
      end
      tmc_pkg::TMC_PCPWM: begin
        ovfSet = ~q.countUp & atBot;
        if (q.countUp) begin
          if (atMax) begin
            upNext  = 1'b0;
            cntNext = q.count - tmc_pkg::TMC_STEP;
          end else begin
            cntNext = q.count + tmc_pkg::TMC_STEP;
          end
        end else begin
          if (atBot) begin
            upNext  = 1'b1;
            cntNext = q.count + tmc_pkg::TMC_STEP;
          end else begin
            cntNext = q.count - tmc_pkg::TMC_STEP;
          end
        end
      end
      default: begin
        cntNext = q.count;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d       = q;
    cmpSet  = cmpEvent;
    // two-flop synchroniser; only its second flop feeds the edge detector
    d.syncA = extTickPin;
    d.syncB = q.syncA;
    d.extPrev = q.syncB;

    // counter and match blocking
    // a count write further down overrides this update
    if (tick) begin
      d.count      = cntNext;
      d.countUp    = upNext;
      d.blockMatch = 1'b0;
    end
    // buffered compare value loads at max, the top of both pwm modes
    if (tick & isPwm & atMax) begin
      d.cmpWork = q.cmpBuf;
    end

    // output state from a real match, mode is not a reset of it
    if (cmpEvent) begin
      case (q.mode)
        tmc_pkg::TMC_PCPWM: begin
          case (q.action)
            tmc_pkg::TMC_ACT_CLEAR: d.ocState = ~q.countUp;
            tmc_pkg::TMC_ACT_SET:   d.ocState = q.countUp;
            default:                d.ocState = q.ocState;
          endcase
        end
        default: begin
          case (q.action)
            tmc_pkg::TMC_ACT_TOGGLE: d.ocState = ~q.ocState;
            tmc_pkg::TMC_ACT_CLEAR:  d.ocState = 1'b0;
            tmc_pkg::TMC_ACT_SET:    d.ocState = 1'b1;
            default:                 d.ocState = q.ocState;
          endcase
        end
      endcase
    end else if (tick & atMax & (q.mode == tmc_pkg::TMC_FAST)) begin
      // bottom edge of fast pwm; a match at max keeps the output constant
      case (q.action)
        tmc_pkg::TMC_ACT_CLEAR: d.ocState = 1'b1;
        tmc_pkg::TMC_ACT_SET:   d.ocState = 1'b0;
        default:                d.ocState = q.ocState;
      endcase
    end

    // register writes
    if (wrEn) begin
      case (paddr)
        tmc_pkg::TMC_OFS_CTRLA: begin
          d.mode   = tmc_pkg::tmc_mode_e'(pwdata[tmc_pkg::TMC_MODE_LSB +: 2]);
          d.action = tmc_pkg::tmc_act_e'(pwdata[tmc_pkg::TMC_ACT_LSB +: 2]);
          if (forceEv) begin
            case (tmc_pkg::tmc_act_e'(pwdata[tmc_pkg::TMC_ACT_LSB +: 2]))
              tmc_pkg::TMC_ACT_TOGGLE: d.ocState = ~q.ocState;
              tmc_pkg::TMC_ACT_CLEAR:  d.ocState = 1'b0;
              tmc_pkg::TMC_ACT_SET:    d.ocState = 1'b1;
              default:                 d.ocState = q.ocState;
            endcase
          end
        end
        tmc_pkg::TMC_OFS_CTRLB: begin
          d.clkSel = pwdata[tmc_pkg::TMC_CS_LSB +: 3];
        end
        tmc_pkg::TMC_OFS_COUNT: begin
          d.count      = pwdata[7:0];
          d.blockMatch = 1'b1;
        end
        tmc_pkg::TMC_OFS_CMPA: begin
          d.cmpBuf = pwdata[7:0];
          if (!isPwm) begin
            d.cmpWork = pwdata[7:0];
          end
        end
        tmc_pkg::TMC_OFS_IRQEN: begin
          d.ovfIe = pwdata[tmc_pkg::TMC_OVF_BIT];
          d.cmpIe = pwdata[tmc_pkg::TMC_CMP_BIT];
        end
        tmc_pkg::TMC_OFS_PORT: begin
          d.portData = pwdata[tmc_pkg::TMC_PDATA_BIT];
          d.portDir  = pwdata[tmc_pkg::TMC_PDIR_BIT];
        end
        default: begin
          d.portData = q.portData;
        end
      endcase
    end

    // flags: clears first, a set in the same cycle wins
    // acknowledge and software clear both lose to a set
    if (wrEn & (paddr == tmc_pkg::TMC_OFS_FLAGS) & pwdata[tmc_pkg::TMC_CMP_BIT]) begin
      d.cmpFlag = 1'b0;
    end
    if (wrEn & (paddr == tmc_pkg::TMC_OFS_FLAGS) & pwdata[tmc_pkg::TMC_OVF_BIT]) begin
      d.ovfFlag = 1'b0;
    end
    if (cmpIrqAck) begin
      d.cmpFlag = 1'b0;
    end
    if (ovfIrqAck) begin
      d.ovfFlag = 1'b0;
    end
    if (cmpSet) begin
      d.cmpFlag = 1'b1;
    end
    if (tick & ovfSet) begin
      d.ovfFlag = 1'b1;
    end

    // pin override, driver gated by the direction bit
    // taken from the next state so the pin moves with it
    d.outPin = (d.action != tmc_pkg::TMC_ACT_NONE) ? d.ocState : d.portData;
    d.outOe  = d.portDir;

    // read data captured in the setup phase
    // prdata then stays put through the whole access phase
    if (rdSetup) begin
      d.rdata = 32'h0000_0000;
      case (paddr)
        tmc_pkg::TMC_OFS_CTRLA: begin
          d.rdata[tmc_pkg::TMC_MODE_LSB +: 2] = q.mode;
          d.rdata[tmc_pkg::TMC_ACT_LSB +: 2]  = q.action;
        end
        tmc_pkg::TMC_OFS_CTRLB: d.rdata[tmc_pkg::TMC_CS_LSB +: 3] = q.clkSel;
        tmc_pkg::TMC_OFS_COUNT: d.rdata[7:0] = q.count;
        tmc_pkg::TMC_OFS_CMPA:  d.rdata[7:0] = isPwm ? q.cmpBuf : q.cmpWork;
        tmc_pkg::TMC_OFS_FLAGS: begin
          d.rdata[tmc_pkg::TMC_OVF_BIT] = q.ovfFlag;
          d.rdata[tmc_pkg::TMC_CMP_BIT] = q.cmpFlag;
        end
        tmc_pkg::TMC_OFS_IRQEN: begin
          d.rdata[tmc_pkg::TMC_OVF_BIT] = q.ovfIe;
          d.rdata[tmc_pkg::TMC_CMP_BIT] = q.cmpIe;
        end
        tmc_pkg::TMC_OFS_PORT: begin
          d.rdata[tmc_pkg::TMC_PDATA_BIT] = q.portData;
          d.rdata[tmc_pkg::TMC_PDIR_BIT]  = q.portDir;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.count   <= tmc_pkg::TMC_RST_COUNT;
      q.cmpWork <= tmc_pkg::TMC_RST_CMP;
      q.cmpBuf  <= tmc_pkg::TMC_RST_CMP;
      // count upward first, so phase correct starts from bottom
      q.countUp <= 1'b1;
      q.mode    <= tmc_pkg::TMC_NORMAL;
      q.action  <= tmc_pkg::TMC_ACT_NONE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata          = q.rdata;
  assign cmpIrq          = q.cmpFlag & q.cmpIe;
  assign ovfIrq          = q.ovfFlag & q.ovfIe;
  assign compareOutPin   = q.outPin;
  assign compareOutPinOe = q.outOe;

endmodule // tmc_timer8

// >>> dv/tmc_checker.sv
// checker: port-level assertions for the timer slice
// assumes: bound to tmc_timer8; register effects mirrored from apb writes
`timescale 1ns/1ps

module tmc_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cmpIrqAck,
  input wire logic        ovfIrqAck,
  input wire logic        cmpIrq,
  input wire logic        ovfIrq,
  input wire logic        compareOutPin,
  input wire logic        compareOutPinOe
);
  // ---------------------------------------------------------------
  // mirror of written fields
  // ---------------------------------------------------------------
  logic [1:0] act_q;
  logic       port_q;
  logic       cmpEn_q;
  logic       ovfEn_q;
  wire        wr     = psel && penable && pwrite;
  wire        wrFlg  = wr && paddr == tmc_pkg::TMC_OFS_FLAGS;
  wire        wrIen  = wr && paddr == tmc_pkg::TMC_OFS_IRQEN;
  wire        cmpClr = cmpIrqAck || (wrFlg && pwdata[1]) || (wrIen && !pwdata[1]);
  wire        ovfClr = ovfIrqAck || (wrFlg && pwdata[0]) || (wrIen && !pwdata[0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_q <= 2'h0;
      port_q <= 1'b0;
      cmpEn_q <= 1'b0;
      ovfEn_q <= 1'b0;
    end else if (wr) begin
      if (paddr == tmc_pkg::TMC_OFS_CTRLA) act_q <= pwdata[5:4];
      if (paddr == tmc_pkg::TMC_OFS_PORT) port_q <= pwdata[0];
      if (paddr == tmc_pkg::TMC_OFS_IRQEN) cmpEn_q <= pwdata[1];
      if (paddr == tmc_pkg::TMC_OFS_IRQEN) ovfEn_q <= pwdata[0];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sWrPort;
    wr && paddr == tmc_pkg::TMC_OFS_PORT;
  endsequence

  a_pin_port: assert property (act_q == 2'h0 |-> compareOutPin == port_q)
    else $error("pin does not follow port data");
  a_oe_write: assert property (sWrPort |=> compareOutPinOe == $past(pwdata[1]))
    else $error("pin enable not taken from direction");
  a_oe_hold: assert property (!wr |=> $stable(compareOutPinOe))
    else $error("pin enable changed without write");
  a_cmp_mask: assert property (!cmpEn_q |-> !cmpIrq)
    else $error("compare request while disabled");
  a_ovf_mask: assert property (!ovfEn_q |-> !ovfIrq)
    else $error("overflow request while disabled");
  a_cmp_clear: assert property ($fell(cmpIrq) |-> $past(cmpClr))
    else $error("compare request dropped without cause");
  a_ovf_clear: assert property ($fell(ovfIrq) |-> $past(ovfClr))
    else $error("overflow request dropped without cause");
  a_bad_addr: assert property (psel && penable && paddr > tmc_pkg::TMC_OFS_PORT
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_good_addr: assert property (psel && penable && paddr[1:0] == 2'h0 &&
    paddr <= tmc_pkg::TMC_OFS_PORT |-> pready && !pslverr)
    else $error("mapped access refused");
endmodule // tmc_checker

bind tmc_timer8 tmc_checker i_tmc_checker (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cmpIrqAck(cmpIrqAck), .ovfIrqAck(ovfIrqAck),
  .cmpIrq(cmpIrq), .ovfIrq(ovfIrq), .compareOutPin(compareOutPin),
  .compareOutPinOe(compareOutPinOe)
);

// >>> dv/tb.sv
// testbench: apb register sequences with expected values for the timer slice
// assumes: zero-wait apb slave, tick from prescaleTick at clock select 2
`timescale 1ns/1ps

module tb;
  localparam logic [7:0] A_CA  = tmc_pkg::TMC_OFS_CTRLA;
  localparam logic [7:0] A_CB  = tmc_pkg::TMC_OFS_CTRLB;
  localparam logic [7:0] A_CNT = tmc_pkg::TMC_OFS_COUNT;
  localparam logic [7:0] A_CMP = tmc_pkg::TMC_OFS_CMPA;
  localparam logic [7:0] A_FLG = tmc_pkg::TMC_OFS_FLAGS;
  localparam logic [7:0] A_IEN = tmc_pkg::TMC_OFS_IRQEN;
  localparam logic [7:0] A_PRT = tmc_pkg::TMC_OFS_PORT;
  logic [7:0]  ofs [7] = '{A_CA, A_CB, A_CNT, A_CMP, A_FLG, A_IEN, A_PRT};
  // expected {enable, pin} in the top bits, control value below
  logic [9:0]  frc [7] = '{10'h3b0, 10'h312, 10'h280, 10'h310, 10'h2a0, 10'h3b3, 10'h390};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, err;
  logic        prescaleTick = 1'b0;
  logic        extTickPin = 1'b0;
  logic        cmpIrqAck = 1'b0;
  logic        ovfIrqAck = 1'b0;
  logic        cmpIrq, ovfIrq, compareOutPin, compareOutPinOe;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  always #5 clk = ~clk;

  tmc_timer8 i_tmc_timer8 (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prescaleTick(prescaleTick), .extTickPin(extTickPin),
    .cmpIrqAck(cmpIrqAck), .ovfIrqAck(ovfIrqAck), .cmpIrq(cmpIrq),
    .ovfIrq(ovfIrq), .compareOutPin(compareOutPin),
    .compareOutPinOe(compareOutPinOe)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      prescaleTick <= 1'b1;
      @(posedge clk);
      prescaleTick <= 1'b0;
    end
  endtask

  task automatic pinChk(input logic [1:0] exp);
    @(negedge clk);
    chk({30'h0, compareOutPinOe, compareOutPin}, {30'h0, exp});
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (ofs[i]) rdChk(ofs[i], 32'h0);
    wr(A_CNT, 32'h55);
    ticks(3);
    rdChk(A_CNT, 32'h55);
    wr(A_CB, 32'h2);
    wr(A_CNT, 32'hfe);
    ticks(3);
    rdChk(A_CNT, 32'h1);
    rdChk(A_FLG, 32'h3);
    wr(A_FLG, 32'h3);
    rdChk(A_FLG, 32'h0);
    wr(A_CMP, 32'h10);
    wr(A_CNT, 32'h10);
    ticks(1);
    rdChk(A_FLG, 32'h0);
    wr(A_CNT, 32'h0f);
    ticks(2);
    rdChk(A_FLG, 32'h2);
    prescaleTick <= 1'b1;
    wr(A_CNT, 32'h40);
    prescaleTick <= 1'b0;
    rdChk(A_CNT, 32'h40);
    // interrupt requests, then acknowledge
    wr(A_CNT, 32'hff);
    ticks(2);
    wr(A_IEN, 32'h3);
    pinChk(2'b00);
    chk({30'h0, cmpIrq, ovfIrq}, 32'h3);
    @(posedge clk);
    cmpIrqAck <= 1'b1;
    ovfIrqAck <= 1'b1;
    @(posedge clk);
    cmpIrqAck <= 1'b0;
    ovfIrqAck <= 1'b0;
    rdChk(A_FLG, 32'h0);
    wr(A_IEN, 32'h0);
    // pwm compare value waits in its buffer until max
    wr(A_CA, 32'h3);
    wr(A_CMP, 32'h20);
    rdChk(A_CMP, 32'h20);
    wr(A_CNT, 32'h1f);
    ticks(2);
    rdChk(A_FLG, 32'h0);
    wr(A_CNT, 32'hfe);
    ticks(2);
    wr(A_FLG, 32'h3);
    wr(A_CNT, 32'h1f);
    ticks(2);
    rdChk(A_FLG, 32'h2);
    // force strobe, actions and mode changes on the pin
    wr(A_CB, 32'h0);
    wr(A_FLG, 32'h3);
    wr(A_CA, 32'h0);
    wr(A_CA, 32'hb0);
    pinChk(2'b01);
    wr(A_PRT, 32'h2);
    pinChk(2'b11);
    foreach (frc[i]) begin
      wr(A_CA, {24'h0, frc[i][7:0]});
      pinChk(frc[i][9:8]);
    end
    rdChk(A_CNT, 32'h21);
    rdChk(A_FLG, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // external rising edges as the tick
    wr(A_CB, 32'h7);
    wr(A_CNT, 32'h30);
    repeat (3) begin
      repeat (4) @(posedge clk);
      extTickPin <= 1'b1;
      repeat (4) @(posedge clk);
      extTickPin <= 1'b0;
    end
    repeat (6) @(posedge clk);
    rdChk(A_CNT, 32'h33);
    stop_test();
  end
endmodule // tb
